// file: common/smhp_defines.svh
// constants for the scan master host port: map, bases, reset values
`ifndef SMHP_DEFINES_SVH
`define SMHP_DEFINES_SVH
// host address map, five address lines
`define SMHP_A_INDEX 5'h0C
`define SMHP_A_OUT 5'h0D
`define SMHP_A_RET 5'h0E
`define SMHP_A_EXP 5'h0F
`define SMHP_A_MASK 5'h10
`define SMHP_A_VEC_IDX 5'h11
`define SMHP_A_VEC 5'h12
`define SMHP_A_HT_IDX 5'h13
`define SMHP_A_HT 5'h14
`define SMHP_A_MAC_IDX 5'h15
`define SMHP_A_MAC 5'h16
`define SMHP_A_SEQ_IDX 5'h17
`define SMHP_A_SEQ 5'h18
`define SMHP_A_BRG_IDX 5'h19
`define SMHP_A_BRG 5'h1A
// region base addresses, long-word units
`define SMHP_B_OUT 11'h000
`define SMHP_B_RET 11'h1C0
`define SMHP_B_EXP 11'h380
`define SMHP_B_MASK 11'h540
`define SMHP_B_VEC 11'h700
`define SMHP_B_HT 11'h708
`define SMHP_B_MAC 11'h788
`define SMHP_B_SEQ 11'h798
`define SMHP_B_BRG 11'h7B8
// control/status register window is addresses below this
`define SMHP_A_REG_TOP 5'h0C
// reset value of pointers and capture registers
`define SMHP_RST_PTR 11'h000
`define SMHP_RST_WORD 16'h0000
`endif

// file: common/smhp_pkg.sv
// types of the scan master host port
package smhp_pkg;
  typedef enum logic [7:0] {
    SMHP_IDLE = 8'h01,
    SMHP_DECODE = 8'h02,
    SMHP_MEM_RD = 8'h04,
    SMHP_MEM_WAIT = 8'h08,
    SMHP_CAPTURE = 8'h10,
    SMHP_ACK = 8'h20,
    SMHP_HOLD = 8'h40,
    SMHP_WRITE = 8'h80
  } smhp_state_t;
endpackage

// file: common/smhp_mem_if.sv
// host-side port of the shared buffer memory
`timescale 1ns/1ps
`default_nettype none
interface smhp_mem_if #(parameter int AW = 11, parameter int DW = 32);
  logic wr_en;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  modport ctrl (output wr_en, output addr, output wdata, input rdata);
  modport mem (input wr_en, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// file: logic/smhp_dpram.sv
// dual-port buffer memory, registered read data on both ports
`timescale 1ns/1ps
`default_nettype none
module smhp_dpram #(
  parameter int AW = 11,
  parameter int DW = 32
) (
  input wire logic clk_sys_i,
  smhp_mem_if.mem host,
  input wire logic scan_wr_en_i,
  input wire logic [AW-1:0] scan_addr_i,
  input wire logic [DW-1:0] scan_wdata_i,
  output logic [DW-1:0] scan_rdata_o
);
  logic [DW-1:0] store_r [0:(1<<AW)-1];
  logic [DW-1:0] host_rd_r;
  assign host.rdata = host_rd_r;
  // both ports in one process so the array has a single writer;
  // no interlock: on a same-word clash the scan side write lands last
  always_ff @(posedge clk_sys_i) begin
    if (host.wr_en) begin
      store_r[host.addr] <= host.wdata; // R4
    end
    if (scan_wr_en_i) begin
      store_r[scan_addr_i] <= scan_wdata_i; // R2
    end
    host_rd_r <= store_r[host.addr];
    scan_rdata_o <= store_r[scan_addr_i];
  end
endmodule
`default_nettype wire

// file: logic/smhp_host_port.sv
// host port: strobe sync, access sequencer, width converter, decoder
`timescale 1ns/1ps
`default_nettype none
`include "smhp_defines.svh"
// Behaviour
// R1: a 2048 by 32 dual-port buffer shared by host and scan side.
// R2: memory is big-endian; scan side addresses it flat with one pointer.
// R3: every host-visible region has its own pointer inside this port.
// R4: conflicting writes are not blocked; both sides may write scan return.
// R5: host software should avoid writing the scan return region.
// R6: four 16-bit capture registers: read low/high pair, write low/high pair.
// R7: write captures have separate loads; 32-bit mode loads both together.
// R8: high write capture input muxed between 16-bit and 32-bit bus.
// R9: read pair uses one load and a select; fixed in 32-bit mode.
// R10: low read capture muxes register/memory in, 16/32-bit out.
// R11: bus width comes from a setup mode bit; the rest is internal.
// R12: asynchronous host: enable and strobe pass two flops before edges.
// R13: edge finder gives one-clock pulses on falling and rising edges.
// R14: access starts on enable and strobe edges, moves data by direction.
// R15: sequencer drives three capture loads and the upper-half select.
// R16: sequencer decides when the memory read or write enable issues.
// R17: decoder holds six index and four address registers as pointers.
// R18: general index write loads four address registers with base plus offset.
// R19: all pointers but general index increment after each long-word region access.
// R20: decoder makes control/status enables and register/memory select.
// R21: acknowledge asserts on the edge the strobe falling edge is seen; here it asserts 2 to 5 clocks after that edge.
// R22: acknowledge withdraws when the strobe rising edge is seen.
// R23: 16-bit memory write takes two word writes, memory written on second.
// R24: first 16-bit memory read acks after five clocks, second after three.
// R25: reset zeroes pointers and captures and idles the sequencer.
module smhp_host_port #(
  parameter int AW = 11,
  parameter int DW = 32,
  parameter bit ASYNC_HOST = 1'b1
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic chip_enable_n_i,
  input wire logic access_strobe_n_i,
  input wire logic read_not_write_i,
  input wire logic [4:0] host_addr_i,
  input wire logic [31:0] host_wdata_i,
  input wire logic bus_is_32_i,
  output logic transfer_ack_n_o,
  output logic [31:0] host_rdata_o,
  output logic ctrl_reg_wr_o,
  output logic status_reg_rd_o,
  output logic [4:0] reg_addr_o,
  output logic [15:0] reg_wdata_o,
  input wire logic [15:0] reg_rdata_i,
  output logic [AW-1:0] out_ptr_o,
  output logic [AW-1:0] ret_ptr_o,
  input wire logic scan_wr_en_i,
  input wire logic [AW-1:0] scan_addr_i,
  input wire logic [DW-1:0] scan_wdata_i,
  output logic [DW-1:0] scan_rdata_o
);
  initial begin
    if (AW != 11 || DW != 32) begin
      $error("smhp_host_port serves only a 2048 x 32 buffer");
    end
  end

  smhp_mem_if #(.AW(AW), .DW(DW)) mem_bus ();

  smhp_dpram #(.AW(AW), .DW(DW)) u_buffer ( // R1
    .clk_sys_i(clk_sys_i),
    .host(mem_bus.mem),
    .scan_wr_en_i(scan_wr_en_i),
    .scan_addr_i(scan_addr_i),
    .scan_wdata_i(scan_wdata_i),
    .scan_rdata_o(scan_rdata_o)
  );

  // transition finder: two-flop sync for an asynchronous host
  logic [1:0] ce_sync_r;
  logic [1:0] stb_sync_r;
  logic ce_q_r;
  logic stb_q_r;
  logic ce_now;
  logic stb_now;
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ce_sync_r <= 2'h3;
      stb_sync_r <= 2'h3;
    end else begin
      ce_sync_r <= {ce_sync_r[0], chip_enable_n_i}; // R12
      stb_sync_r <= {stb_sync_r[0], access_strobe_n_i}; // R12
    end
  end
  // a synchronous host skips the sync stages
  assign ce_now = ASYNC_HOST ? ce_sync_r[1] : chip_enable_n_i;
  assign stb_now = ASYNC_HOST ? stb_sync_r[1] : access_strobe_n_i;

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ce_q_r <= 1'b1;
      stb_q_r <= 1'b1;
    end else begin
      ce_q_r <= ce_now;
      stb_q_r <= stb_now;
    end
  end
  // one-clock pulses on both strobe edges and the enable falling edge
  logic stb_fall;
  logic stb_rise;
  logic ce_fall;
  assign stb_fall = stb_q_r & ~stb_now; // R13
  assign stb_rise = ~stb_q_r & stb_now; // R13
  assign ce_fall = ce_q_r & ~ce_now; // R13
  // chip enable seen low, either just now or earlier in the access
  logic start_go;
  assign start_go = stb_fall & (~ce_now | ce_fall); // R14

  // inputs registered at the strobe edge
  logic rnw_r;
  logic [4:0] addr_r;
  logic [31:0] wdata_r;
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rnw_r <= 1'b1;
      addr_r <= 5'h00;
      wdata_r <= 32'h0000_0000;
    end else if (start_go && state_r == smhp_pkg::SMHP_IDLE) begin
      rnw_r <= read_not_write_i;
      addr_r <= host_addr_i;
      wdata_r <= host_wdata_i;
    end
  end

  // address decoder: region hits and register window
  logic is_reg;
  logic is_mem;
  logic is_idx;
  assign is_reg = addr_r < `SMHP_A_REG_TOP; // R20
  assign is_idx = addr_r == `SMHP_A_INDEX;
  always_comb begin
    case (addr_r)
      `SMHP_A_OUT, `SMHP_A_RET, `SMHP_A_EXP, `SMHP_A_MASK,
      `SMHP_A_VEC, `SMHP_A_HT, `SMHP_A_MAC, `SMHP_A_SEQ,
      `SMHP_A_BRG: is_mem = 1'b1;
      default: is_mem = 1'b0;
    endcase
  end

  // access sequencer
  smhp_pkg::smhp_state_t state_r;
  logic half_hi_r; // second word of a 16-bit long-word pair pending
  logic mem_step; // pointer advance after a completed long-word access
  logic mem_wr;
  logic rd_load;
  logic wr_lo_load;
  logic wr_hi_load;
  logic upper_half_read_select_r;
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= smhp_pkg::SMHP_IDLE; // R25
      half_hi_r <= 1'b0;
    end else begin
      case (state_r)
        smhp_pkg::SMHP_IDLE: begin
          if (start_go) begin
            state_r <= smhp_pkg::SMHP_DECODE; // R14
          end
        end
        smhp_pkg::SMHP_DECODE: begin
          if (!rnw_r) begin
            state_r <= smhp_pkg::SMHP_WRITE;
          end else if (is_mem && !half_hi_r) begin
            state_r <= smhp_pkg::SMHP_MEM_RD;
          end else begin
            state_r <= smhp_pkg::SMHP_CAPTURE;
          end
        end
        smhp_pkg::SMHP_MEM_RD: begin
          state_r <= smhp_pkg::SMHP_MEM_WAIT; // R16
        end
        smhp_pkg::SMHP_MEM_WAIT: begin
          state_r <= smhp_pkg::SMHP_CAPTURE; // R24
        end
        smhp_pkg::SMHP_CAPTURE: begin
          state_r <= smhp_pkg::SMHP_ACK;
          if (is_mem && !bus_is_32_i) begin
            half_hi_r <= ~half_hi_r;
          end
        end
        smhp_pkg::SMHP_WRITE: begin
          state_r <= smhp_pkg::SMHP_HOLD;
          if (is_mem && !bus_is_32_i) begin
            half_hi_r <= ~half_hi_r; // R23
          end
        end
        smhp_pkg::SMHP_ACK: begin
          state_r <= smhp_pkg::SMHP_HOLD;
        end
        smhp_pkg::SMHP_HOLD: begin
          if (stb_rise) begin
            state_r <= smhp_pkg::SMHP_IDLE; // R22
          end
        end
        default: begin
          state_r <= smhp_pkg::SMHP_IDLE;
        end
      endcase
    end
  end

  // sequencer strobes into converter and memory
  logic pair_done;
  assign pair_done = bus_is_32_i | half_hi_r; // R11
  assign mem_wr = (state_r == smhp_pkg::SMHP_WRITE) & is_mem & pair_done; // R16
  assign rd_load = (state_r == smhp_pkg::SMHP_CAPTURE) & (is_reg | is_idx
    | is_mem & ~half_hi_r); // R15
  // 16-bit pair: high half takes the first word, low half the second
  assign wr_lo_load = (state_r == smhp_pkg::SMHP_DECODE) & ~rnw_r
    & (bus_is_32_i | ~is_mem | half_hi_r); // R7
  assign wr_hi_load = (state_r == smhp_pkg::SMHP_DECODE) & ~rnw_r
    & (bus_is_32_i | ~half_hi_r); // R7
  assign mem_step = is_mem & pair_done & ((state_r == smhp_pkg::SMHP_WRITE)
    | (state_r == smhp_pkg::SMHP_CAPTURE & rnw_r)); // R19

  // upper-half select flips only in 16-bit mode
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      upper_half_read_select_r <= 1'b0;
    end else if (bus_is_32_i) begin
      upper_half_read_select_r <= 1'b0; // R9
    end else if (state_r == smhp_pkg::SMHP_CAPTURE && is_mem) begin
      upper_half_read_select_r <= ~half_hi_r; // R15
    end
  end

  // word width converter capture registers
  logic [15:0] rd_lo_r;
  logic [15:0] rd_hi_r;
  logic [15:0] wr_lo_r;
  logic [15:0] wr_hi_r;
  logic [15:0] wr_hi_in;
  // first 16-bit word is the high half: memory is big-endian
  assign wr_hi_in = bus_is_32_i ? wdata_r[31:16] : wdata_r[15:0]; // R8
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_lo_r <= `SMHP_RST_WORD; // R25
      wr_hi_r <= `SMHP_RST_WORD;
    end else begin
      if (wr_hi_load) begin
        wr_hi_r <= wr_hi_in; // R6
      end
      if (wr_lo_load) begin
        wr_lo_r <= wdata_r[15:0];
      end
    end
  end
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_lo_r <= `SMHP_RST_WORD; // R25
      rd_hi_r <= `SMHP_RST_WORD;
    end else if (rd_load) begin
      rd_lo_r <= is_reg ? reg_rdata_i : is_idx ? 16'(idx_gen_r)
        : mem_bus.rdata[15:0]; // R10
      rd_hi_r <= (is_reg || is_idx) ? 16'h0000 : mem_bus.rdata[31:16]; // R6
    end
  end

  // output side of the read pair and the acknowledge
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      host_rdata_o <= 32'h0000_0000;
      transfer_ack_n_o <= 1'b1;
    end else begin
      if (state_r == smhp_pkg::SMHP_ACK) begin
        if (bus_is_32_i) begin
          host_rdata_o <= {rd_hi_r, rd_lo_r}; // R9
        end else if (is_mem) begin
          host_rdata_o <= {16'h0000, upper_half_read_select_r ? rd_hi_r
            : rd_lo_r}; // R10
        end else begin
          host_rdata_o <= {16'h0000, rd_lo_r};
        end
      end
      if (state_r == smhp_pkg::SMHP_WRITE || state_r == smhp_pkg::SMHP_ACK) begin
        transfer_ack_n_o <= 1'b0; // R21
      end else if (stb_rise) begin
        transfer_ack_n_o <= 1'b1; // R22
      end
    end
  end

  // control and status enables to outside units
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_reg_wr_o <= 1'b0;
      status_reg_rd_o <= 1'b0;
      reg_addr_o <= 5'h00;
      reg_wdata_o <= 16'h0000;
    end else begin
      ctrl_reg_wr_o <= (state_r == smhp_pkg::SMHP_WRITE) & is_reg; // R20
      status_reg_rd_o <= rd_load & is_reg; // R20
      reg_addr_o <= addr_r;
      reg_wdata_o <= wdata_r[15:0];
    end
  end

  // pointers: one per region
  logic [AW-1:0] idx_gen_r;
  logic [AW-1:0] ptr_r [0:8];
  logic [AW-1:0] base_v [0:8];
  logic [4:0] region_a [0:8];
  logic [4:0] index_a [0:8];
  assign base_v = '{`SMHP_B_OUT, `SMHP_B_RET, `SMHP_B_EXP, `SMHP_B_MASK,
    `SMHP_B_VEC, `SMHP_B_HT, `SMHP_B_MAC, `SMHP_B_SEQ, `SMHP_B_BRG};
  assign region_a = '{`SMHP_A_OUT, `SMHP_A_RET, `SMHP_A_EXP, `SMHP_A_MASK,
    `SMHP_A_VEC, `SMHP_A_HT, `SMHP_A_MAC, `SMHP_A_SEQ, `SMHP_A_BRG};
  assign index_a = '{`SMHP_A_INDEX, `SMHP_A_INDEX, `SMHP_A_INDEX,
    `SMHP_A_INDEX, `SMHP_A_VEC_IDX, `SMHP_A_HT_IDX, `SMHP_A_MAC_IDX,
    `SMHP_A_SEQ_IDX, `SMHP_A_BRG_IDX};
  logic idx_wr;
  assign idx_wr = state_r == smhp_pkg::SMHP_WRITE;
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      idx_gen_r <= `SMHP_RST_PTR; // R25
    end else if (idx_wr && addr_r == `SMHP_A_INDEX) begin
      idx_gen_r <= wdata_r[AW-1:0]; // R17
    end
  end
  // regions 0-3 are the four address registers, 4-8 the indexed ones
  genvar g;
  generate
    for (g = 0; g < 9; g++) begin : g_ptr
      always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          ptr_r[g] <= `SMHP_RST_PTR; // R25
        end else if (idx_wr && addr_r == index_a[g]) begin
          // address registers hold base plus offset, indexes the offset
          ptr_r[g] <= (g < 4) ? AW'(base_v[g] + wdata_r[AW-1:0])
            : wdata_r[AW-1:0]; // R18
        end else if (mem_step && addr_r == region_a[g]) begin
          ptr_r[g] <= ptr_r[g] + 1'b1; // R19
        end
      end
    end
  endgenerate

  // memory address for the current region: address register as held, or base plus index
  logic [AW-1:0] mem_addr;
  always_comb begin
    mem_addr = '0;
    for (int i = 0; i < 9; i++) begin
      if (addr_r == region_a[i]) begin
        mem_addr = (i < 4) ? ptr_r[i] : AW'(base_v[i] + ptr_r[i]); // R3
      end
    end
  end
  assign mem_bus.wr_en = mem_wr;
  assign mem_bus.addr = mem_addr;
  assign mem_bus.wdata = {wr_hi_r, wr_lo_r};

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      out_ptr_o <= `SMHP_RST_PTR;
      ret_ptr_o <= `SMHP_RST_PTR;
    end else begin
      out_ptr_o <= ptr_r[0];
      ret_ptr_o <= ptr_r[1];
    end
  end
endmodule
`default_nettype wire

// file: testbench/smhp_host_port_assertions.sv
// checker for the host port handshake, register strobes and reset state
`timescale 1ns/1ps
`default_nettype none
module smhp_host_port_assertions #(
  parameter int AW = 11
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic chip_enable_n_i,
  input wire logic access_strobe_n_i,
  input wire logic read_not_write_i,
  input wire logic transfer_ack_n_o,
  input wire logic ctrl_reg_wr_o,
  input wire logic status_reg_rd_o,
  input wire logic [4:0] reg_addr_o,
  input wire logic [AW-1:0] out_ptr_o,
  input wire logic [AW-1:0] ret_ptr_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  // bound covers two sync flops plus the slowest read
  a_ack_after_stb: assert property ($fell(access_strobe_n_i) &&
    !chip_enable_n_i |-> ##[2:12] !transfer_ack_n_o)
    else $error("ack did not follow strobe");
  a_ack_release: assert property ($rose(access_strobe_n_i) &&
    !transfer_ack_n_o |-> ##[1:6] transfer_ack_n_o)
    else $error("ack not withdrawn after strobe rise");
  a_ack_needs_stb: assert property ($fell(transfer_ack_n_o)
    |-> !access_strobe_n_i)
    else $error("ack without strobe");
  a_ack_holds: assert property ($fell(transfer_ack_n_o)
    |-> !transfer_ack_n_o [*2])
    else $error("ack dropped before strobe rise");
  a_wr_one_pulse: assert property (ctrl_reg_wr_o |=> !ctrl_reg_wr_o)
    else $error("control write longer than a cycle");
  a_rd_one_pulse: assert property (status_reg_rd_o
    |=> !status_reg_rd_o)
    else $error("status read longer than a cycle");
  a_reg_window: assert property (ctrl_reg_wr_o || status_reg_rd_o
    |-> reg_addr_o < 5'h0C)
    else $error("register enable outside register window");
  a_wr_dir: assert property (ctrl_reg_wr_o |-> !read_not_write_i)
    else $error("control write during a read");
  a_reset_idle: assert property ($rose(reset_n_i) |->
    transfer_ack_n_o && out_ptr_o == 11'h000 && ret_ptr_o == 11'h000)
    else $error("port not idle after reset");
  c_read: cover property ($fell(transfer_ack_n_o) && read_not_write_i);
  c_reg_wr: cover property (ctrl_reg_wr_o);
  c_reg_rd: cover property (status_reg_rd_o);
endmodule
`default_nettype wire

// file: testbench/smhp_host_model.sv
// host processor model driving the strobe/acknowledge bus
`timescale 1ns/1ps
`default_nettype none
module smhp_host_model (
  input wire logic clk_sys_i,
  input wire logic transfer_ack_n_i,
  input wire logic [31:0] host_rdata_i,
  output logic ce_n_o,
  output logic stb_n_o,
  output logic rnw_o,
  output logic [4:0] addr_o,
  output logic [31:0] wdata_o
);
  initial begin
    ce_n_o = 1'b1;
    stb_n_o = 1'b1;
    rnw_o = 1'b1;
    addr_o = 5'h1F;
    wdata_o = 32'hA5A5A5A5;
  end
  // one access; cyc counts edges from strobe fall to ack
  task automatic access(input logic rnw, input logic [4:0] a,
      input logic [31:0] d, output logic [31:0] rd, output int cyc,
      output bit ok);
    int n;
    ok = 1'b0;
    @(negedge clk_sys_i);
    ce_n_o = 1'b0;
    rnw_o = rnw;
    addr_o = a;
    wdata_o = d;
    stb_n_o = 1'b0;
    // strobe and qualifiers held until ack is seen low
    for (n = 0; n < 40; n++) begin
      @(posedge clk_sys_i);
      if (transfer_ack_n_i === 1'b0) break;
    end
    cyc = n;
    rd = host_rdata_i;
    @(negedge clk_sys_i);
    // released lines carry the inverse so stale values never match
    stb_n_o = 1'b1;
    ce_n_o = 1'b1;
    addr_o = ~a;
    wdata_o = ~d;
    // no new access before ack is withdrawn
    for (int m = 0; m < 40; m++) begin
      @(posedge clk_sys_i);
      if (transfer_ack_n_i === 1'b1) begin
        ok = (n < 40);
        break;
      end
    end
    // hand back on a falling edge so callers drive off the sampling edge
    @(negedge clk_sys_i);
  endtask
endmodule
`default_nettype wire

// file: testbench/tb_scan_master_host_port.sv
// self-checking bench for the scan master host port
`timescale 1ns/1ps
`default_nettype none
`include "smhp_defines.svh"
module tb_scan_master_host_port;
  logic clk_sys_i, reset_n_i, ce_n, stb_n, rnw, bus32, ack_n;
  logic ctrl_wr, stat_rd, scan_we;
  logic [4:0] haddr, reg_addr;
  logic [31:0] hwdata, hrdata, scan_wdata, scan_rdata, rd, v, hi, lo;
  logic [15:0] reg_wdata, reg_rdata;
  logic [10:0] out_ptr, ret_ptr, scan_addr, k;
  logic [31:0] mem_m [int];
  logic [4:0] rg_a [4] = '{5'h0D, 5'h0E, 5'h0F, 5'h10};
  logic [10:0] rg_b [4] = '{`SMHP_B_OUT, `SMHP_B_RET, `SMHP_B_EXP,
    `SMHP_B_MASK};
  int err_total, samples_checked, c1, c2;
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  smhp_host_model host (.clk_sys_i(clk_sys_i), .transfer_ack_n_i(ack_n),
    .host_rdata_i(hrdata), .ce_n_o(ce_n), .stb_n_o(stb_n), .rnw_o(rnw),
    .addr_o(haddr), .wdata_o(hwdata));
  smhp_host_port uut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .chip_enable_n_i(ce_n), .access_strobe_n_i(stb_n),
    .read_not_write_i(rnw), .host_addr_i(haddr), .host_wdata_i(hwdata),
    .bus_is_32_i(bus32), .transfer_ack_n_o(ack_n), .host_rdata_o(hrdata),
    .ctrl_reg_wr_o(ctrl_wr), .status_reg_rd_o(stat_rd),
    .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata),
    .reg_rdata_i(reg_rdata), .out_ptr_o(out_ptr), .ret_ptr_o(ret_ptr),
    .scan_wr_en_i(scan_we), .scan_addr_i(scan_addr),
    .scan_wdata_i(scan_wdata), .scan_rdata_o(scan_rdata));
  task automatic chk(input string nm, input logic [31:0] s,
      input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic end_sim();
    if (err_total == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // a hung handshake ends the run at once
  task automatic hacc(input logic r, input logic [4:0] a,
      input logic [31:0] d, output int cyc);
    bit ok;
    host.access(r, a, d, rd, cyc, ok);
    if (!ok) begin
      chk("handshake", 32'(ok), 32'h1);
      end_sim();
    end
  endtask
  task automatic swr(input logic [10:0] a, input logic [31:0] d);
    @(negedge clk_sys_i);
    scan_we = 1'b1;
    scan_addr = a;
    scan_wdata = d;
    mem_m[a] = d;
    @(negedge clk_sys_i);
    scan_we = 1'b0;
    scan_wdata = ~d;
  endtask
  // scan read data is registered, one cycle behind the address
  task automatic scheck(input logic [10:0] a);
    @(negedge clk_sys_i);
    scan_addr = a;
    @(negedge clk_sys_i);
    chk("scan_rdata", scan_rdata, mem_m[a]);
  endtask
  initial begin
    void'($urandom(55728));
    {err_total, samples_checked} = 0;
    {reset_n_i, bus32, scan_we, scan_addr, scan_wdata, reg_rdata} = 0;
    repeat (2) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    reset_n_i = 1'b1;
    chk("ack_n", ack_n, 1);
    chk("out_ptr", out_ptr, 0);
    // register window: write then read back through outside units
    for (int i = 0; i < 4; i++) begin
      v = $urandom;
      hi = $urandom_range(0, 11);
      hacc(1'b0, hi[4:0], v, c1);
      chk("reg_addr", reg_addr, hi[4:0]);
      chk("reg_wdata", reg_wdata, v[15:0]);
      reg_rdata = v[31:16];
      hacc(1'b1, hi[4:0], 32'h0, c1);
      chk("reg rdata", rd[15:0], v[31:16]);
    end
    k = 11'($urandom_range(0, 63));
    hacc(1'b0, `SMHP_A_INDEX, 32'(k), c1);
    chk("out_ptr", out_ptr, `SMHP_B_OUT + k);
    chk("ret_ptr", ret_ptr, `SMHP_B_RET + k);
    hacc(1'b1, `SMHP_A_INDEX, 32'h0, c1);
    chk("index rd", rd, 32'(k));
    // 16-bit pair: memory untouched until the second word
    swr(`SMHP_B_OUT + k, $urandom);
    hi = $urandom;
    lo = $urandom;
    hacc(1'b0, `SMHP_A_OUT, hi, c1);
    scheck(`SMHP_B_OUT + k);
    hacc(1'b0, `SMHP_A_OUT, lo, c1);
    mem_m[`SMHP_B_OUT + k] = {hi[15:0], lo[15:0]};
    scheck(`SMHP_B_OUT + k);
    chk("out_ptr", out_ptr, `SMHP_B_OUT + k + 1);
    v = $urandom;
    // return region filled by the scan side; the host only reads it here
    swr(`SMHP_B_RET + k, v);
    hacc(1'b1, `SMHP_A_RET, 32'h0, c1);
    chk("rd high", rd[15:0], v[31:16]);
    hacc(1'b1, `SMHP_A_RET, 32'h0, c2);
    chk("rd low", rd[15:0], v[15:0]);
    chk("read gap", c1 - c2, 2);
    chk("ret_ptr", ret_ptr, `SMHP_B_RET + k + 1);
    // 32-bit bus: one access per long word in each of the four address-register regions
    @(negedge clk_sys_i);
    bus32 = 1'b1;
    hacc(1'b0, `SMHP_A_INDEX, 32'(k), c1);
    for (int i = 0; i < 4; i++) begin
      v = $urandom;
      hacc(1'b0, rg_a[i], v, c1);
      mem_m[rg_b[i] + k] = v;
      scheck(rg_b[i] + k);
    end
    chk("ret_ptr", ret_ptr, `SMHP_B_RET + k + 1);
    v = $urandom;
    swr(`SMHP_B_RET + k + 1, v);
    hacc(1'b1, `SMHP_A_RET, 32'h0, c1);
    chk("rd 32", rd, v);
    // second reset in mid-run
    @(negedge clk_sys_i);
    reset_n_i = 1'b0;
    #1;
    chk("ret_ptr", ret_ptr, 0);
    @(negedge clk_sys_i);
    reset_n_i = 1'b1;
    hacc(1'b0, `SMHP_A_OUT, 32'h0, c1);
    chk("out_ptr", out_ptr, 1);
    end_sim();
  end
endmodule
bind smhp_host_port smhp_host_port_assertions #(.AW(AW)) u_chk (
  .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
  .chip_enable_n_i(chip_enable_n_i), .access_strobe_n_i(access_strobe_n_i),
  .read_not_write_i(read_not_write_i), .transfer_ack_n_o(transfer_ack_n_o),
  .ctrl_reg_wr_o(ctrl_reg_wr_o), .status_reg_rd_o(status_reg_rd_o),
  .reg_addr_o(reg_addr_o), .out_ptr_o(out_ptr_o), .ret_ptr_o(ret_ptr_o));
`default_nettype wire
